// ### rtl/dmaar_pkg.sv
// package: shared constants and types for the dma channel address/request block
`default_nettype none
package dmaar_pkg;
   localparam int          ADDR_W          = 32;
   localparam int          DATA_W          = 32;
   localparam int          FIFO_DEPTH      = 32;
   // address direction codes
   localparam logic [1:0]  DIR_INC         = 2'h0;
   localparam logic [1:0]  DIR_DEC         = 2'h1;
   localparam logic [1:0]  DIR_FIXED       = 2'h2;
   // count bit select codes, bit position is four times the code
   localparam logic [2:0]  CNT_BIT0        = 3'h0;
   localparam logic [2:0]  CNT_BIT8        = 3'h2;
   localparam logic [2:0]  CNT_MAX         = 3'h4;
   // transfer unit size codes, bits 3:2 of the channel control word
   localparam int          SIZE_LSB        = 2;
   localparam logic [1:0]  SIZE_32         = 2'h0;
   localparam logic [1:0]  SIZE_16         = 2'h2;
   localparam logic [1:0]  SIZE_8          = 2'h3;
   localparam int          LEVEL_BIT       = 12;
   localparam int          POLARITY_BIT    = 13;
   localparam logic [31:0] BYTES_32        = 32'h0000_0004;
   localparam logic [31:0] BYTES_16        = 32'h0000_0002;
   localparam logic [31:0] BYTES_8         = 32'h0000_0001;
   // reset values
   localparam logic [ADDR_W-1:0] ADDR_RST  = 32'h0000_0000;
   localparam logic [31:0] COUNT_RST       = 32'h0000_0000;
   localparam logic        PIN_IDLE        = 1'b1;
   typedef enum logic [1:0] {DMAAR_IDLE, DMAAR_STANDBY, DMAAR_XFER, DMAAR_ACK} dmaar_state_t;
endpackage : dmaar_pkg
`default_nettype wire

// ### rtl/dmaar_link_if.sv
// interface: request and acknowledge wires between the channel and its requesters
`default_nettype none
interface dmaar_link_if;
   logic interrupt_controller_dma_request_n;
   logic ext_request_pin_two;
   logic ext_request_pin_three;
   logic port_f_function_ctrl;
   logic port_j_function_ctrl;
   logic dma_acknowledge_n;
   logic [31:0] unit_data;
   modport channel (input interrupt_controller_dma_request_n, input ext_request_pin_two, input ext_request_pin_three,
                    input port_f_function_ctrl, input port_j_function_ctrl, input unit_data,
                    output dma_acknowledge_n);
   modport requester (output interrupt_controller_dma_request_n, output ext_request_pin_two, output ext_request_pin_three,
                      output port_f_function_ctrl, output port_j_function_ctrl, output unit_data,
                      input dma_acknowledge_n);
endinterface : dmaar_link_if
`default_nettype wire

// ### rtl/dmaar_fifo.sv
// synchronous fifo with valid/ready on both sides
`default_nettype none
module dmaar_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 32
) (
   input  wire logic             i_ref_clk,
   input  wire logic             i_rst,
   input  wire logic [WIDTH-1:0] i_wr_data,
   input  wire logic             i_wr_valid,
   output logic                  o_wr_ready,
   output logic [WIDTH-1:0]      o_rd_data,
   output logic                  o_rd_valid,
   input  wire logic             i_rd_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr_reg;
   logic [AW-1:0]    rd_ptr_reg;
   logic [AW:0]      count_reg;
   wire              push = i_wr_valid && o_wr_ready;
   wire              pop  = o_rd_valid && i_rd_ready;
   assign o_wr_ready = (count_reg != (AW+1)'(DEPTH));
   assign o_rd_valid = (count_reg != '0);
   assign o_rd_data  = mem[rd_ptr_reg];
   always_ff @(posedge i_ref_clk)
   begin
      if (push)
      begin
         mem[wr_ptr_reg] <= i_wr_data;
      end
   end
   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg  <= '0;
      end
      else
      begin
         wr_ptr_reg <= push ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
         rd_ptr_reg <= pop ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
         count_reg  <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule : dmaar_fifo
`default_nettype wire

// ### rtl/dmaar_channel.sv
// dma channel end: address counters, request detection, acknowledge and unit buffer
// Notes on behaviour
// - source and destination increment, decrement or fixed
// - software fixes the address of io sides
// - count bit selectable: 0,4,8,12,16
// - code 010 is bit 8, 000 bit 0
// - bit 0 sequential, higher bits strided
// - each channel chooses internal or external request
// - internal mode: start raises request immediately
// - internal request holds until channel finishes
// - internal mode only for memory to memory
// - external mode: start enters standby first
// - one accepted request moves one unit, except an interrupt_controller memory request, which moves all units
// - acknowledge on io cycles, memory at zero
// - interrupt_controller io requests move one unit each
// - port f wins when both route requests
// - edge requester releases and reasserts each time
// - level for memory, edge for io input
// - level mode samples low each clock, ack low
// - level requester holds low until acknowledge
// - level pin high means no request, standby
// - edge is low after previous high sample
// - edge after acknowledge continues without gap
// - acknowledge marks every io device access
`default_nettype none
module dmaar_channel
   import dmaar_pkg::*;
(
   input  wire logic                   i_ref_clk,
   input  wire logic                   i_rst,
   dmaar_link_if.channel               link,
   input  wire logic                   i_start,
   input  wire logic                   i_external_request_select,
   input  wire logic                   i_use_interrupt_controller,
   input  wire logic [31:0]            i_channel_control_reg,
   input  wire logic [1:0]             i_src_addr_direction,
   input  wire logic [1:0]             i_dst_addr_direction,
   input  wire logic [2:0]             i_src_count_bit_select,
   input  wire logic [2:0]             i_dst_count_bit_select,
   input  wire logic                   i_src_is_io,
   input  wire logic                   i_dst_is_io,
   input  wire logic [dmaar_pkg::ADDR_W-1:0] i_src_addr_init,
   input  wire logic [dmaar_pkg::ADDR_W-1:0] i_dst_addr_init,
   input  wire logic [31:0]            i_byte_count_init,
   input  wire logic                   i_bus_grant,
   output logic [dmaar_pkg::ADDR_W-1:0] o_src_addr,
   output logic [dmaar_pkg::ADDR_W-1:0] o_dst_addr,
   output logic [31:0]                 o_byte_count,
   output logic                        o_unit_strobe,
   output logic                        o_active,
   output logic                        o_standby,
   output logic [dmaar_pkg::DATA_W-1:0] o_unit_data,
   output logic                        o_unit_valid,
   input  wire logic                   i_unit_ready
);
   dmaar_state_t                state_reg;
   dmaar_state_t                state_next;
   logic [ADDR_W-1:0]           src_reg;
   logic [ADDR_W-1:0]           dst_reg;
   logic [31:0]                 count_reg;
   logic                        pin_prev_reg;
   logic                        ack_n_reg;
   logic                        strobe_reg;
   logic                        active_reg;
   logic                        standby_reg;
   logic [DATA_W-1:0]           out_data_reg;
   logic                        out_valid_reg;
   // select level or edge detection from control bits; polarity bit must be zero
   wire logic [1:0] unit_code   = i_channel_control_reg[SIZE_LSB+1:SIZE_LSB];
   wire logic       level_mode  = i_channel_control_reg[LEVEL_BIT];
   wire logic       pol_ok      = !i_channel_control_reg[POLARITY_BIT];
   // port f has priority over port j when both carry the request
   wire logic       pin_n       = link.port_f_function_ctrl ? link.ext_request_pin_two :
                                  link.port_j_function_ctrl ? link.ext_request_pin_three : PIN_IDLE;
   wire logic       pin_level   = pol_ok && !pin_n;
   wire logic       pin_edge    = pol_ok && !pin_n && pin_prev_reg;
   wire logic       ext_req     = i_use_interrupt_controller ? !link.interrupt_controller_dma_request_n :
                                  (level_mode ? pin_level : pin_edge);
   // internal request holds for the life of the channel
   wire logic       request     = i_external_request_select ? ext_req : 1'b1;
   wire logic [31:0] unit_bytes = (unit_code == SIZE_16) ? BYTES_16 :
                                  (unit_code == SIZE_8)  ? BYTES_8  : BYTES_32;
   wire logic [31:0] count_left = count_reg - unit_bytes;
   wire logic       io_xfer     = i_src_is_io || i_dst_is_io;
   wire logic       last_unit   = (count_left == 32'h0000_0000);
   // the fifo stalls a unit while full, so the buffer really back-pressures the channel
   wire logic       fifo_ready;
   wire logic       fifo_valid;
   wire logic [DATA_W-1:0] fifo_data;
   // one register after the fifo keeps the unit outputs on flip-flops, at the cost of one more unit held
   wire logic       out_load    = !out_valid_reg || i_unit_ready;
   wire logic       fifo_pop    = fifo_valid && out_load;
   wire logic       unit_go     = (state_reg == DMAAR_XFER) && i_bus_grant && fifo_ready;
   wire logic       ack_now     = unit_go && (io_xfer || last_unit);
   // an interrupt_controller line is still low while the acknowledge clears it, so it is no new request then
   wire logic       fresh_req   = request && !(i_external_request_select && i_use_interrupt_controller);

   function automatic logic [ADDR_W-1:0] step_addr(input logic [ADDR_W-1:0] a, input logic [1:0] dir,
                                                  input logic [2:0] sel);
      logic [ADDR_W-1:0] stride;
      logic [2:0]        s;
      s      = (sel > CNT_MAX) ? CNT_BIT0 : sel;
      stride = ADDR_W'(1) << {s, 2'b00};
      if (dir == DIR_INC)
         step_addr = a + stride;
      else if (dir == DIR_DEC)
         step_addr = a - stride;
      else
         step_addr = a;
   endfunction : step_addr

   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         DMAAR_IDLE:
            if (i_start && (i_byte_count_init != 32'h0000_0000))
               state_next = i_external_request_select ? DMAAR_STANDBY : DMAAR_XFER;
         DMAAR_STANDBY:
            if (request)
               state_next = DMAAR_XFER;
         DMAAR_XFER:
            if (unit_go)
            begin
               if (last_unit)
                  state_next = DMAAR_IDLE;
               else if (!i_external_request_select)
                  state_next = DMAAR_XFER;
               else if (i_use_interrupt_controller && !io_xfer)
                  state_next = DMAAR_XFER;
               else
                  state_next = DMAAR_ACK;
            end
         DMAAR_ACK:
            // a fresh request right after the unit continues without a gap, else standby
            state_next = fresh_req ? DMAAR_XFER : DMAAR_STANDBY;
         default:
            state_next = DMAAR_IDLE;
      endcase
   end

   // status follows the next state, so the outputs come from flip-flops without an extra cycle
   wire logic       active_next  = (state_next == DMAAR_XFER) || (state_next == DMAAR_ACK);
   wire logic       standby_next = (state_next == DMAAR_STANDBY);

   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         state_reg    <= DMAAR_IDLE;
         src_reg      <= ADDR_RST;
         dst_reg      <= ADDR_RST;
         count_reg    <= COUNT_RST;
         pin_prev_reg <= PIN_IDLE;
         ack_n_reg    <= 1'b1;
         strobe_reg   <= 1'b0;
         active_reg   <= 1'b0;
         standby_reg  <= 1'b0;
      end
      else
      begin
         state_reg    <= state_next;
         pin_prev_reg <= pin_n;
         ack_n_reg    <= !ack_now;
         strobe_reg   <= unit_go;
         active_reg   <= active_next;
         standby_reg  <= standby_next;
         if (state_reg == DMAAR_IDLE && i_start)
         begin
            src_reg   <= i_src_addr_init;
            dst_reg   <= i_dst_addr_init;
            count_reg <= i_byte_count_init;
         end
         else if (unit_go)
         begin
            src_reg   <= step_addr(src_reg, i_src_addr_direction, i_src_count_bit_select);
            dst_reg   <= step_addr(dst_reg, i_dst_addr_direction, i_dst_count_bit_select);
            count_reg <= count_left;
         end
      end
   end

   dmaar_fifo #(
      .WIDTH (DATA_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .i_ref_clk  (i_ref_clk),
      .i_rst      (i_rst),
      .i_wr_data  (link.unit_data),
      .i_wr_valid (unit_go),
      .o_wr_ready (fifo_ready),
      .o_rd_data  (fifo_data),
      .o_rd_valid (fifo_valid),
      .i_rd_ready (fifo_pop)
   );

   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         out_valid_reg <= 1'b0;
         out_data_reg  <= '0;
      end
      else
      begin
         if (out_load)
         begin
            out_valid_reg <= fifo_valid;
         end
         if (fifo_pop)
         begin
            out_data_reg <= fifo_data;
         end
      end
   end

   assign link.dma_acknowledge_n = ack_n_reg;
   assign o_src_addr    = src_reg;
   assign o_dst_addr    = dst_reg;
   assign o_byte_count  = count_reg;
   assign o_unit_strobe = strobe_reg;
   assign o_active      = active_reg;
   assign o_standby     = standby_reg;
   assign o_unit_data   = out_data_reg;
   assign o_unit_valid  = out_valid_reg;
endmodule : dmaar_channel
`default_nettype wire

// ### rtl/dmaar_requester.sv
// requester end: drives interrupt_controller and pin requests, edge or level, releases on acknowledge
// the far party: holds level until ack, and pulses high between edge requests
`default_nettype none
module dmaar_requester
   import dmaar_pkg::*;
(
   input  wire logic        i_ref_clk,
   input  wire logic        i_rst,
   dmaar_link_if.requester  link,
   input  wire logic        i_interrupt_controller_event,
   input  wire logic        i_pin_request,
   input  wire logic        i_edge_mode,
   input  wire logic        i_route_port_f,
   input  wire logic        i_route_port_j,
   input  wire logic [31:0] i_data,
   output logic             o_acked
);
   logic interrupt_controller_n_reg;
   logic pin_n_reg;
   logic acked_reg;
   logic fence_reg;
   wire logic ack = !link.dma_acknowledge_n;
   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         interrupt_controller_n_reg <= 1'b1;
         pin_n_reg  <= 1'b1;
         acked_reg  <= 1'b0;
         fence_reg  <= 1'b0;
      end
      else
      begin
         acked_reg <= ack;
         // interrupt_controller request is set by event and cleared by acknowledge; a new event wins
         if (i_interrupt_controller_event)
            interrupt_controller_n_reg <= 1'b0;
         else if (ack)
            interrupt_controller_n_reg <= 1'b1;
         // level held until acknowledge; edge requests release for one cycle after each
         if (ack || fence_reg)
         begin
            pin_n_reg <= 1'b1;
            fence_reg <= 1'b0;
         end
         else if (i_pin_request)
         begin
            pin_n_reg <= 1'b0;
            fence_reg <= i_edge_mode && !pin_n_reg;
         end
         else
            pin_n_reg <= 1'b1;
      end
   end
   assign link.interrupt_controller_dma_request_n    = interrupt_controller_n_reg;
   assign link.ext_request_pin_two   = pin_n_reg;
   // with both ports routed the request travels on the port f pin only, so the channel must pick it
   assign link.ext_request_pin_three = i_route_port_f ? PIN_IDLE : pin_n_reg;
   assign link.port_f_function_ctrl  = i_route_port_f;
   assign link.port_j_function_ctrl  = i_route_port_j;
   assign link.unit_data             = i_data;
   assign o_acked                    = acked_reg;
endmodule : dmaar_requester
`default_nettype wire

// ### bench/dmaar_link_assertions.sv
// checker: timing relations on the request and acknowledge wires
`default_nettype none
module dmaar_link_assertions (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic interrupt_controller_dma_request_n,
   input wire logic ext_request_pin_two,
   input wire logic ext_request_pin_three,
   input wire logic dma_acknowledge_n
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (i_rst);
   ack_one_cycle_a: assert property (!dma_acknowledge_n |=> dma_acknowledge_n)
      else $error("acknowledge held longer than one cycle");
   reset_idle_a: assert property ($past(i_rst) |-> dma_acknowledge_n ##1 dma_acknowledge_n)
      else $error("acknowledge active right after reset");
   reset_pins_a: assert property ($past(i_rst) |-> interrupt_controller_dma_request_n && ext_request_pin_two)
      else $error("request lines not idle after reset");
   interrupt_controller_hold_a: assert property ($fell(interrupt_controller_dma_request_n) |=> !interrupt_controller_dma_request_n)
      else $error("interrupt_controller request dropped before acknowledge");
   interrupt_controller_clear_a: assert property (!dma_acknowledge_n && !interrupt_controller_dma_request_n |-> ##[1:2] interrupt_controller_dma_request_n)
      else $error("interrupt_controller request not cleared by acknowledge");
   pin_two_release_a: assert property (!dma_acknowledge_n && !ext_request_pin_two |-> ##[1:6] ext_request_pin_two)
      else $error("pin two not released after acknowledge");
   pin_three_release_a: assert property (!dma_acknowledge_n && !ext_request_pin_three |->
      ##[1:6] ext_request_pin_three)
      else $error("pin three not released after acknowledge");
endmodule : dmaar_link_assertions
`default_nettype wire

// ### bench/dmaar_channel_addr_and_request_bench.sv
// bench: channel and requester joined, random and corner runs
`default_nettype none
module dmaar_channel_addr_and_request_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import dmaar_pkg::*;
   logic i_ref_clk = 1'b0;
   logic i_rst = 1'b1;
   logic start = 1'b0, ext = 1'b0, use_interrupt_controller = 1'b0, sio = 1'b0, dio = 1'b0, grant = 1'b0, urdy = 1'b0;
   logic ievt = 1'b0, preq = 1'b0, edge_m = 1'b0, rf = 1'b0, rj = 1'b0, pend = 1'b0, hold = 1'b0;
   logic [31:0] ctrl = '0, sinit = '0, dinit = '0, cnt = '0, data = '0, seed = 32'h7314B436;
   logic [1:0] sdir = '0, ddir = '0;
   logic [2:0] ssel = '0, dsel = '0;
   logic [31:0] src, dst, bc, udata;
   logic strobe, active, standby, uvalid, acked;
   int error_cnt = 0, checks_done = 0, nstr, nack, i;
   dmaar_link_if link ();
   dmaar_channel u_dmaar_channel (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .link(link), .i_start(start),
      .i_external_request_select(ext), .i_use_interrupt_controller(use_interrupt_controller), .i_channel_control_reg(ctrl),
      .i_src_addr_direction(sdir), .i_dst_addr_direction(ddir), .i_src_count_bit_select(ssel),
      .i_dst_count_bit_select(dsel), .i_src_is_io(sio), .i_dst_is_io(dio), .i_src_addr_init(sinit),
      .i_dst_addr_init(dinit), .i_byte_count_init(cnt), .i_bus_grant(grant), .o_src_addr(src),
      .o_dst_addr(dst), .o_byte_count(bc), .o_unit_strobe(strobe), .o_active(active), .o_standby(standby),
      .o_unit_data(udata), .o_unit_valid(uvalid), .i_unit_ready(urdy));
   dmaar_requester u_dmaar_requester (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .link(link), .i_interrupt_controller_event(ievt),
      .i_pin_request(preq), .i_edge_mode(edge_m), .i_route_port_f(rf), .i_route_port_j(rj), .i_data(data),
      .o_acked(acked));
   dmaar_link_assertions u_dmaar_link_assertions (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
      .interrupt_controller_dma_request_n(link.interrupt_controller_dma_request_n), .ext_request_pin_two(link.ext_request_pin_two),
      .ext_request_pin_three(link.ext_request_pin_three), .dma_acknowledge_n(link.dma_acknowledge_n));
   always #25 i_ref_clk = ~i_ref_clk;
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs
   // expected address after k units; step ignores unit size by design choice
   function automatic logic [31:0] ea(input logic [31:0] a, input logic [1:0] d, input logic [2:0] s, input int k);
      logic [31:0] st;
      st = 32'h1 << (4 * s);
      return (d == DIR_INC) ? a + 32'(k) * st : (d == DIR_DEC) ? a - 32'(k) * st : a;
   endfunction : ea
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : report_and_stop
   task automatic reset_dut();
      i_rst <= 1'b1;
      repeat (6) @(posedge i_ref_clk);
      i_rst <= 1'b0;
   endtask : reset_dut
   // requesters react to standby; edge mode gets a fresh fall each time the pin is re-raised
   always @(posedge i_ref_clk)
   begin
      if (i_rst)
      begin
         preq <= 1'b0;
         ievt <= 1'b0;
         pend <= 1'b0;
      end
      else
      begin
         if (strobe)
         begin
            nstr++;
            chk(src, ea(sinit, sdir, ssel, nstr));
            chk(dst, ea(dinit, ddir, dsel, nstr));
         end
         if (!link.dma_acknowledge_n)
            nack++;
         if (uvalid && urdy)
            chk(udata, data);
         ievt <= use_interrupt_controller && ext && standby && !pend && !ievt;
         pend <= (pend || ievt) && !acked;
         preq <= !use_interrupt_controller && ext && (standby || (preq && !acked));
         urdy <= !hold && (xs() % 4 != 0);
         grant <= (xs() % 4 != 0);
      end
   end
   task automatic run(input logic e, input logic ic, input logic lv, input logic io, input logic [1:0] sz,
                      input int n, input logic pol, input logic [31:0] k);
      logic [31:0] b;
      int t;
      b = (sz == SIZE_16) ? BYTES_16 : (sz == SIZE_8) ? BYTES_8 : BYTES_32;
      @(posedge i_ref_clk);
      ext <= e;
      use_interrupt_controller <= ic;
      edge_m <= !lv;
      sio <= io && k[2];
      dio <= io && !k[2];
      ctrl <= (32'(pol) << POLARITY_BIT) | (32'(lv) << LEVEL_BIT) | (32'(sz) << SIZE_LSB);
      sdir <= (io && k[2]) ? DIR_FIXED : 2'(k % 4);
      ddir <= (io && !k[2]) ? DIR_FIXED : 2'(k % 3);
      ssel <= 3'(k % 5);
      dsel <= 3'((k + 2) % 5);
      rf <= !k[0] || k[1];
      rj <= k[0];
      sinit <= xs();
      dinit <= xs();
      data <= xs();
      cnt <= 32'(n) * b;
      start <= 1'b1;
      nstr = 0;
      nack = 0;
      @(posedge i_ref_clk);
      start <= 1'b0;
      for (t = 0; t < 3000; t++)
      begin
         @(posedge i_ref_clk);
         #1;
         if (t == 0)
            chk(standby, e && n != 0);
         if (hold && t == 200)
         begin
            chk(nstr, FIFO_DEPTH + 1);
            hold = 1'b0;
         end
         if (t > 40 && (pol || !(active || standby)))
            break;
      end
      repeat (3) @(posedge i_ref_clk);
      #1;
      // drain the unit buffer so that no old word meets the next run's data
      for (t = 0; t < 200 && uvalid; t++)
      begin
         @(posedge i_ref_clk);
         #1;
      end
      chk(uvalid, 1'b0);
      chk(nstr, pol ? 0 : n);
      chk(nack, (pol || n == 0) ? 0 : io ? n : 1);
      chk(bc, pol ? 32'(n) * b : 32'h0);
      chk(src, ea(sinit, sdir, ssel, pol ? 0 : n));
      $display("run done units %0d seen %0d", n, nstr);
   endtask : run
   initial
   begin
      reset_dut();
      for (i = 0; i < 12; i++)
         run(1'b0, 1'b0, 1'b0, 1'b0, 2'(xs()), 1 + i % 5, 1'b0, 32'(i));
      run(1'b1, 1'b1, 1'b0, 1'b1, SIZE_16, 4, 1'b0, xs());
      run(1'b1, 1'b1, 1'b0, 1'b0, SIZE_8, 5, 1'b0, xs());
      run(1'b1, 1'b0, 1'b1, 1'b0, SIZE_32, 4, 1'b0, xs());
      run(1'b1, 1'b0, 1'b1, 1'b1, SIZE_16, 3, 1'b0, 32'h3);
      run(1'b1, 1'b0, 1'b0, 1'b1, SIZE_8, 4, 1'b0, xs());
      hold = 1'b1;
      run(1'b0, 1'b0, 1'b0, 1'b0, SIZE_8, 40, 1'b0, xs());
      run(1'b1, 1'b0, 1'b0, 1'b0, SIZE_32, 0, 1'b0, xs());
      run(1'b1, 1'b0, 1'b1, 1'b0, SIZE_32, 3, 1'b1, xs());
      @(posedge i_ref_clk);
      reset_dut();
      run(1'b0, 1'b0, 1'b0, 1'b0, SIZE_16, 2, 1'b0, 32'h4);
      report_and_stop();
   end
   // watchdog: all runs finish far inside this span
   initial
   begin
      #(50 * 40000);
      error_cnt++;
      report_and_stop();
   end
endmodule : dmaar_channel_addr_and_request_bench
`default_nettype wire
